// File: verilog/power_seq_pkg.sv
// Constants, register map and shared types of the power sequencer.
// Assumes a single 10 MHz system clock and a synchronous reset.
package power_seq_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_US = 50;
    localparam int TICK_CYCLES_DFLT = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int TICKS_PER_MS = 1000 / TICK_US;
    localparam int DELAY_US [8] = '{0, 2100, 3150, 5250,
                                    6300, 8400, 16800, 33600};

    // Bus layout
    localparam int ADR_W = 9;
    localparam int IDX_MSB = 8;
    localparam int IDX_LSB = 2;
    localparam int REG_W = 8;

    // Register indices, byte address is four times the index
    localparam logic [6:0] IDX_OVERVOLT = 7'h03;
    localparam logic [6:0] IDX_OVERCURRENT = 7'h04;
    localparam logic [6:0] IDX_ENABLE_PRIMARY = 7'h05;
    localparam logic [6:0] IDX_ENABLE_SECONDARY = 7'h06;
    localparam logic [6:0] IDX_DELAY_CH12 = 7'h07;
    localparam logic [6:0] IDX_DELAY_CH34 = 7'h08;
    localparam logic [6:0] IDX_DELAY_SW = 7'h09;
    localparam logic [6:0] IDX_IRQ_STATUS = 7'h40;
    localparam logic [6:0] IDX_IRQ_MASK = 7'h41;
    localparam logic [6:0] IDX_SEQ_CONTROL = 7'h42;

    // Reset values and write masks
    localparam logic [7:0] ENABLE_PRIMARY_RST = 8'hE5;
    localparam logic [7:0] ENABLE_SECONDARY_RST = 8'h00;
    localparam logic [7:0] DELAY_CH12_RST = 8'h00;
    localparam logic [7:0] DELAY_CH34_RST = 8'h00;
    localparam logic [7:0] DELAY_SW_RST = 8'h10;
    localparam logic [7:0] SECONDARY_WMASK = 8'h3F;
    localparam logic [7:0] DELAY_WMASK = 8'h3F;

    // Field positions
    localparam int NUM_CH = 4;
    localparam int NUM_PATHS = 3;
    localparam int NUM_DELAYED = 6;
    localparam int DELAY_FIELD_MSB = 5;
    localparam int GATE_LSB = 3;
    localparam int GATE_MSB = 5;
    localparam int OVERRIDE_MSB = 2;
    localparam int IRQ_OC_LSB = 0;
    localparam int IRQ_OV_LSB = 3;
    localparam int IRQ_SEQ_BIT = 7;
    localparam int SEQ_RESTART_BIT = 0;
    localparam int SEQ_RUN_BIT = 0;
    localparam int SEQ_DONE_BIT = 1;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_DONE = 2'b11
    } seq_state_t;

    typedef logic [5:0] latency_t;

    typedef struct packed {
        latency_t [NUM_PATHS-1:0] path;
    } latency_cfg_t;

    typedef struct packed {
        logic [5:0] ms_cnt;
        logic fired;
        logic fault;
    } latency_state_t;

endpackage

// File: verilog/fault_latency_timer.sv
// Fault latency timer for one current-sense path.
// Assumes a synchronised condition and a one-cycle millisecond tick.
`timescale 1ns/1ps
`default_nettype none
module fault_latency_timer
    import power_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Timing
    input wire logic ms_tick_i,
    input wire latency_t latency_i,
    // Condition
    input wire logic condition_i,
    input wire logic override_i,
    output logic fault_o
);

    latency_state_t state_reg;
    latency_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.fault = 1'b0;
        // Condition gone or ignored restarts the wait
        if (!condition_i || override_i)
        begin
            state_next.ms_cnt = '0;
            state_next.fired = 1'b0;
        end
        else if (!state_reg.fired)
        begin
            if (state_reg.ms_cnt >= latency_i)
            begin
                state_next.fault = 1'b1;
                state_next.fired = 1'b1;
            end
            else if (ms_tick_i)
            begin
                state_next.ms_cnt = state_reg.ms_cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign fault_o = state_reg.fault;

    property p_fault_needs_cond;
        @(posedge clk_i) disable iff (rst_i)
        fault_o |-> $past(condition_i) && !$past(override_i);
    endproperty
    a_fault_needs_cond: assert property (p_fault_needs_cond)
        else $error("latency fault without a held condition");

endmodule
`default_nettype wire

// File: verilog/power_sequencer_status_regs.sv
// Status, enable and start-up delay registers with the power-up sequencer.
// Assumes a classic Wishbone master on clk_i and asynchronous monitor pins.
//
// Function
// - Four live overvoltage flags, channel four on top
// - Overvoltage flags never masked by anything
// - Three overcurrent flags set on path faults
// - Overcurrent flag cleared only by writing one
// - Flag set only after latency timer expires
// - Override bit blocks its path's overcurrent flag
// - Override bits in low three secondary bits
// - Primary enable bits map eight outputs
// - Sequencer starts enabled outputs, then direct control
// - Gate driver enables in secondary bits five-three
// - Delay codes select eight fixed start-up waits
// - Delay fields paired, odd output low bits
// - Switch two delay resets to code two
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module power_sequencer_status_regs
    import power_seq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Monitor pins
    input wire logic [NUM_CH-1:0] overvolt_i,
    input wire logic [NUM_PATHS-1:0] overcurrent_i,
    input wire latency_cfg_t latency_cfg_i,
    // Power control
    output logic [7:0] output_on_o,
    output logic [NUM_PATHS-1:0] gate_driver_on_o,
    output logic [NUM_PATHS-1:0] path_shutdown_o,
    output logic sequence_done_o,
    output logic irq_o
);

    typedef struct packed {
        seq_state_t seq;
        logic [NUM_CH-1:0] overvolt_s1;
        logic [NUM_CH-1:0] overvolt_s2;
        logic [NUM_CH-1:0] overvolt_d;
        logic [NUM_PATHS-1:0] overcurrent_s1;
        logic [NUM_PATHS-1:0] overcurrent_s2;
        logic [NUM_PATHS-1:0] overcurrent_flag;
        logic [7:0] enable_primary;
        logic [7:0] enable_secondary;
        logic [7:0] delay_ch12;
        logic [7:0] delay_ch34;
        logic [7:0] delay_sw;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [11:0] tick_cnt;
        logic tick;
        logic [4:0] ms_cnt;
        logic ms_tick;
        logic [9:0] elapsed;
        logic [NUM_DELAYED-1:0] started;
        logic [7:0] output_on;
        logic [NUM_PATHS-1:0] gate_on;
        logic [NUM_PATHS-1:0] shutdown;
        logic ack;
        logic [7:0] rdata;
    } core_state_t;

    core_state_t core_reg;
    core_state_t core_next;

    logic access;
    logic wr;
    logic [6:0] idx;
    logic [REG_W-1:0] wbyte;
    logic [7:0] events;
    logic [NUM_PATHS-1:0] fault_pulse;
    logic [NUM_PATHS-1:0] override;
    logic [NUM_DELAYED-1:0][2:0] delay_codes;

    function automatic logic hit(input logic [6:0] a, input logic [6:0] t);
        hit = (a == t);
    endfunction

    function automatic logic [9:0] delay_ticks(input logic [2:0] code);
        delay_ticks = 10'(DELAY_US[code] / TICK_US);
    endfunction

    assign override = core_reg.enable_secondary[OVERRIDE_MSB:0];
    // Odd-numbered output in the low field of each pair
    assign delay_codes = {core_reg.delay_sw[DELAY_FIELD_MSB:0],
                          core_reg.delay_ch34[DELAY_FIELD_MSB:0],
                          core_reg.delay_ch12[DELAY_FIELD_MSB:0]};

    generate
        for (genvar p = 0; p < NUM_PATHS; p++)
        begin : g_path
            fault_latency_timer u_timer (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ms_tick_i(core_reg.ms_tick),
                .latency_i(latency_cfg_i.path[p]),
                .condition_i(core_reg.overcurrent_s2[p]),
                .override_i(override[p]),
                .fault_o(fault_pulse[p])
            );
        end
    endgenerate

    always_comb
    begin
        core_next = core_reg;
        access = wb_cyc_i & wb_stb_i & ~core_reg.ack;
        // Writes land on the edge where the master sees ack
        wr = core_reg.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
        idx = wb_adr_i[IDX_MSB:IDX_LSB];
        wbyte = wb_dat_i[REG_W-1:0];
        events = '0;

        // Time base shared by the sequencer and latency timers
        core_next.tick = 1'b0;
        core_next.ms_tick = 1'b0;
        if (core_reg.tick_cnt == 12'(TICK_CYCLES - 1))
        begin
            core_next.tick_cnt = '0;
            core_next.tick = 1'b1;
        end
        else
        begin
            core_next.tick_cnt = core_reg.tick_cnt + 12'h001;
        end
        if (core_reg.tick)
        begin
            if (core_reg.ms_cnt == 5'(TICKS_PER_MS - 1))
            begin
                core_next.ms_cnt = '0;
                core_next.ms_tick = 1'b1;
            end
            else
            begin
                core_next.ms_cnt = core_reg.ms_cnt + 5'h01;
            end
        end

        // Pin synchronisers
        core_next.overvolt_s1 = overvolt_i;
        core_next.overvolt_s2 = core_reg.overvolt_s1;
        core_next.overvolt_d = core_reg.overvolt_s2;
        core_next.overcurrent_s1 = overcurrent_i;
        core_next.overcurrent_s2 = core_reg.overcurrent_s1;

        events[IRQ_OC_LSB +: NUM_PATHS] = fault_pulse & ~override;
        events[IRQ_OV_LSB +: NUM_CH] = core_reg.overvolt_s2 &
                                       ~core_reg.overvolt_d;

        // Set wins over a simultaneous write-one clear
        if (wr && hit(idx, IDX_OVERCURRENT))
        begin
            core_next.overcurrent_flag = core_reg.overcurrent_flag &
                                         ~wbyte[NUM_PATHS-1:0];
        end
        core_next.overcurrent_flag = core_next.overcurrent_flag |
                                     (fault_pulse & ~override);

        if (wr)
        begin
            if (hit(idx, IDX_ENABLE_PRIMARY))
            begin
                core_next.enable_primary = wbyte;
            end
            if (hit(idx, IDX_ENABLE_SECONDARY))
            begin
                core_next.enable_secondary = wbyte & SECONDARY_WMASK;
            end
            if (hit(idx, IDX_DELAY_CH12))
            begin
                core_next.delay_ch12 = wbyte & DELAY_WMASK;
            end
            if (hit(idx, IDX_DELAY_CH34))
            begin
                core_next.delay_ch34 = wbyte & DELAY_WMASK;
            end
            if (hit(idx, IDX_DELAY_SW))
            begin
                core_next.delay_sw = wbyte & DELAY_WMASK;
            end
            if (hit(idx, IDX_IRQ_MASK))
            begin
                core_next.irq_mask = wbyte;
            end
        end

        // Sequencer, all waits counted from entry to run
        unique case (core_reg.seq)
            SEQ_IDLE:
            begin
                core_next.elapsed = '0;
                core_next.started = '0;
                core_next.seq = SEQ_RUN;
            end
            SEQ_RUN:
            begin
                for (int i = 0; i < NUM_DELAYED; i++)
                begin
                    if (core_reg.elapsed >= delay_ticks(delay_codes[i]))
                    begin
                        core_next.started[i] = 1'b1;
                    end
                end
                if (core_reg.tick)
                begin
                    core_next.elapsed = core_reg.elapsed + 10'h001;
                end
                if (&core_next.started)
                begin
                    core_next.seq = SEQ_DONE;
                    events[IRQ_SEQ_BIT] = 1'b1;
                end
            end
            SEQ_DONE:
            begin
                core_next.seq = SEQ_DONE;
            end
            default:
            begin
                core_next.seq = SEQ_IDLE;
            end
        endcase
        if (wr && hit(idx, IDX_SEQ_CONTROL) && wbyte[SEQ_RESTART_BIT])
        begin
            core_next.seq = SEQ_IDLE;
        end

        // Output drive, outputs without a delay field start at once
        unique case (core_reg.seq)
            SEQ_RUN:
            begin
                core_next.output_on = core_reg.enable_primary &
                                      {2'b11, core_reg.started};
            end
            SEQ_DONE:
            begin
                core_next.output_on = core_reg.enable_primary;
            end
            default:
            begin
                core_next.output_on = '0;
            end
        endcase
        core_next.gate_on = core_reg.enable_secondary[GATE_MSB:GATE_LSB];
        core_next.shutdown = core_reg.overcurrent_flag & ~override;

        // Interrupt status, set wins over clear
        if (wr && hit(idx, IDX_IRQ_STATUS))
        begin
            core_next.irq_status = core_reg.irq_status & ~wbyte;
        end
        core_next.irq_status = core_next.irq_status | events;

        // Read data captured with ack; unmapped reads answer zero
        core_next.ack = access;
        if (access)
        begin
            core_next.rdata = '0;
            if (hit(idx, IDX_OVERVOLT))
            begin
                core_next.rdata[NUM_CH-1:0] = core_reg.overvolt_s2;
            end
            if (hit(idx, IDX_OVERCURRENT))
            begin
                core_next.rdata[NUM_PATHS-1:0] = core_reg.overcurrent_flag &
                                                 ~override;
            end
            if (hit(idx, IDX_ENABLE_PRIMARY))
            begin
                core_next.rdata = core_reg.enable_primary;
            end
            if (hit(idx, IDX_ENABLE_SECONDARY))
            begin
                core_next.rdata = core_reg.enable_secondary;
            end
            if (hit(idx, IDX_DELAY_CH12))
            begin
                core_next.rdata = core_reg.delay_ch12;
            end
            if (hit(idx, IDX_DELAY_CH34))
            begin
                core_next.rdata = core_reg.delay_ch34;
            end
            if (hit(idx, IDX_DELAY_SW))
            begin
                core_next.rdata = core_reg.delay_sw;
            end
            if (hit(idx, IDX_IRQ_STATUS))
            begin
                core_next.rdata = core_reg.irq_status;
            end
            if (hit(idx, IDX_IRQ_MASK))
            begin
                core_next.rdata = core_reg.irq_mask;
            end
            if (hit(idx, IDX_SEQ_CONTROL))
            begin
                core_next.rdata[SEQ_RUN_BIT] = (core_reg.seq == SEQ_RUN);
                core_next.rdata[SEQ_DONE_BIT] = (core_reg.seq == SEQ_DONE);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_reg <= '0;
            core_reg.seq <= SEQ_IDLE;
            core_reg.enable_primary <= ENABLE_PRIMARY_RST;
            core_reg.enable_secondary <= ENABLE_SECONDARY_RST;
            core_reg.delay_ch12 <= DELAY_CH12_RST;
            core_reg.delay_ch34 <= DELAY_CH34_RST;
            core_reg.delay_sw <= DELAY_SW_RST;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    assign wb_ack_o = core_reg.ack;
    assign wb_dat_o = {24'h000000, core_reg.rdata};
    assign output_on_o = core_reg.output_on;
    assign gate_driver_on_o = core_reg.gate_on;
    assign path_shutdown_o = core_reg.shutdown;
    assign sequence_done_o = (core_reg.seq == SEQ_DONE);
    assign irq_o = |(core_reg.irq_status & core_reg.irq_mask);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_overvolt_live;
        ##2 core_reg.overvolt_s2 == $past(overvolt_i, 2);
    endproperty
    a_overvolt_live: assert property (p_overvolt_live)
        else $error("overvoltage flags do not follow the pins");

    property p_overvolt_read;
        access && !wb_we_i && hit(idx, IDX_OVERVOLT) |=>
            wb_dat_o[NUM_CH-1:0] == $past(core_reg.overvolt_s2);
    endproperty
    a_overvolt_read: assert property (p_overvolt_read)
        else $error("overvoltage read differs from live flags");

    property p_oc_hold;
        core_reg.overcurrent_flag[0] &&
            !(wr && hit(idx, IDX_OVERCURRENT) && wbyte[0]) |=>
            core_reg.overcurrent_flag[0];
    endproperty
    a_oc_hold: assert property (p_oc_hold)
        else $error("overcurrent flag lost without a write of one");

    property p_oc_clear;
        wr && hit(idx, IDX_OVERCURRENT) && wbyte[0] && !fault_pulse[0] |=>
            !core_reg.overcurrent_flag[0];
    endproperty
    a_oc_clear: assert property (p_oc_clear)
        else $error("overcurrent flag not cleared by write of one");

    property p_oc_set;
        $rose(core_reg.overcurrent_flag[1]) |-> $past(fault_pulse[1]);
    endproperty
    a_oc_set: assert property (p_oc_set)
        else $error("overcurrent flag set before latency expired");

    property p_oc_masked;
        override[2] && !core_reg.overcurrent_flag[2] |=>
            !core_reg.overcurrent_flag[2];
    endproperty
    a_oc_masked: assert property (p_oc_masked)
        else $error("overcurrent flag set while overridden");

    property p_shutdown;
        core_reg.overcurrent_flag[0] && !override[0] |=> path_shutdown_o[0];
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("faulted path not shut down");

    property p_reset_values;
        $past(rst_i) |-> core_reg.enable_primary == ENABLE_PRIMARY_RST &&
            core_reg.delay_sw == DELAY_SW_RST;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("wrong register values after reset");

    property p_gate_follow;
        wr && hit(idx, IDX_ENABLE_SECONDARY) |=> ##1
            gate_driver_on_o == $past(wb_dat_i[GATE_MSB:GATE_LSB], 2);
    endproperty
    a_gate_follow: assert property (p_gate_follow)
        else $error("gate drivers do not follow their enables");

    property p_start_wait;
        core_reg.seq == SEQ_RUN && output_on_o[1] |->
            core_reg.elapsed >= delay_ticks(delay_codes[1]);
    endproperty
    a_start_wait: assert property (p_start_wait)
        else $error("output started before its delay");

    property p_done_direct;
        core_reg.seq == SEQ_DONE && $past(core_reg.seq) == SEQ_DONE |->
            output_on_o == $past(core_reg.enable_primary);
    endproperty
    a_done_direct: assert property (p_done_direct)
        else $error("enables not applied directly after sequence");

    c_seq_done: cover property (core_reg.seq == SEQ_RUN ##1
                                core_reg.seq == SEQ_DONE);
    c_oc_flag: cover property ($rose(core_reg.overcurrent_flag[0]));
    c_irq: cover property ($rose(irq_o));

endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the power sequencer status registers.
// Assumes the design package and a 10 MHz clock; drives Wishbone directly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import power_seq_pkg::*;

    localparam int TICK = 5;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [NUM_CH-1:0] ov = 4'h0;
    logic [NUM_PATHS-1:0] oc = 3'h0;
    latency_cfg_t lat = '0;
    logic [7:0] out_on;
    logic [NUM_PATHS-1:0] gate_on;
    logic [NUM_PATHS-1:0] shut;
    logic done;
    logic irq;
    int err_total = 0;
    int n_compared = 0;

    // Short tick keeps the 33.6 ms class of delays inside a short run
    power_sequencer_status_regs #(.TICK_CYCLES(TICK)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .overvolt_i(ov), .overcurrent_i(oc), .latency_cfg_i(lat),
        .output_on_o(out_on), .gate_driver_on_o(gate_on),
        .path_shutdown_o(shut), .sequence_done_o(done), .irq_o(irq));

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; holds everything until ack is sampled high
    task automatic bus(input logic w, input logic [6:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
            chk(32'h0, 32'h1, "ack wait");
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdc(input logic [6:0] idx, input logic [7:0] e,
                       input string what);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, {24'h0, e}, what);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run is under 2000 cycles; a hang is cut at 20000
    initial
    begin
        cyc_wait(20000);
        err_total++;
        wrap_up();
    end

    initial
    begin
        cyc_wait(2);
        rst_i <= 1'b0;
        cyc_wait(20);
        chk(out_on, 32'hC5 >> 0, "out_on early");
        chk(done, 1'b0, "done early");
        rdc(IDX_ENABLE_PRIMARY, ENABLE_PRIMARY_RST, "en1 rst");
        rdc(IDX_ENABLE_SECONDARY, 8'h00, "en2 rst");
        rdc(IDX_DELAY_CH12, 8'h00, "dly12 rst");
        rdc(IDX_DELAY_CH34, 8'h00, "dly34 rst");
        rdc(IDX_DELAY_SW, 8'h10, "dlysw rst");
        rdc(IDX_OVERCURRENT, 8'h00, "oc rst");
        rdc(IDX_OVERVOLT, 8'h00, "ov rst");
        rdc(7'h10, 8'h00, "unmapped");
        // Switch two waits code 010: 63 ticks of TICK cycles
        cyc_wait(400);
        chk(out_on, 8'hE5, "out_on seq");
        chk(done, 1'b1, "done");
        rdc(IDX_IRQ_STATUS, 8'h80, "irq status");
        chk(irq, 1'b0, "irq masked");
        wr(IDX_IRQ_MASK, 8'h80);
        cyc_wait(2);
        chk(irq, 1'b1, "irq on");
        wr(IDX_IRQ_STATUS, 8'h80);
        cyc_wait(2);
        chk(irq, 1'b0, "irq cleared");
        wr(IDX_ENABLE_PRIMARY, 8'h0F);
        cyc_wait(2);
        chk(out_on, 8'h0F, "direct enable");
        wr(IDX_ENABLE_SECONDARY, 8'hFF);
        rdc(IDX_ENABLE_SECONDARY, 8'h3F, "en2 mask");
        wr(IDX_ENABLE_SECONDARY, 8'h38);
        cyc_wait(2);
        chk(gate_on, 3'h7, "gate drivers");
        wr(IDX_DELAY_CH12, 8'hFF);
        rdc(IDX_DELAY_CH12, 8'h3F, "dly mask");
        ov <= 4'hA;
        cyc_wait(5);
        rdc(IDX_OVERVOLT, 8'h0A, "ov live");
        // Rising edges of channels two and four land in status bits 4 and 6
        rdc(IDX_IRQ_STATUS, 8'h50, "irq ov");
        ov <= 4'h0;
        oc <= 3'h2;
        cyc_wait(10);
        oc <= 3'h0;
        rdc(IDX_OVERCURRENT, 8'h02, "oc set");
        rdc(IDX_IRQ_STATUS, 8'h52, "irq oc");
        wr(IDX_OVERCURRENT, 8'h00);
        rdc(IDX_OVERCURRENT, 8'h02, "oc keep");
        wr(IDX_OVERCURRENT, 8'h02);
        rdc(IDX_OVERCURRENT, 8'h00, "oc clear");
        // Two ms latency: at most one tick lands in the first 60 cycles
        lat.path[0] <= 6'h02;
        oc <= 3'h1;
        cyc_wait(60);
        rdc(IDX_OVERCURRENT, 8'h00, "oc early");
        cyc_wait(300);
        rdc(IDX_OVERCURRENT, 8'h01, "oc late");
        chk(shut, 3'h1, "shutdown");
        oc <= 3'h0;
        wr(IDX_OVERCURRENT, 8'h01);
        wr(IDX_ENABLE_SECONDARY, 8'h04);
        oc <= 3'h4;
        cyc_wait(20);
        rdc(IDX_OVERCURRENT, 8'h00, "oc override");
        chk(shut, 3'h0, "no shutdown");
        oc <= 3'h0;
        wr(IDX_DELAY_CH12, 8'h08);
        wr(IDX_DELAY_CH34, 8'h00);
        wr(IDX_DELAY_SW, 8'h00);
        wr(IDX_ENABLE_PRIMARY, 8'h03);
        wr(IDX_SEQ_CONTROL, 8'h01);
        // Channel two code 001: 42 ticks after the common start
        cyc_wait(20);
        chk(out_on, 8'h01, "ch2 waiting");
        rdc(IDX_SEQ_CONTROL, 8'h01, "seq run");
        cyc_wait(250);
        chk(out_on, 8'h03, "ch2 started");
        rdc(IDX_SEQ_CONTROL, 8'h02, "seq done");
        wrap_up();
    end
endmodule
`default_nettype wire
